/* File: rtl/tmoirq_consts.vh */
// Constants for the timer overflow interrupt block: register offsets, bit positions,
// reset values and timing counts. Assumes inclusion by every design file of the block.
`ifndef TMOIRQ_CONSTS_VH
`define TMOIRQ_CONSTS_VH

// Register byte offsets on the Wishbone slave.
`define TMO_ADDR_COUNT 4'h0
`define TMO_ADDR_CTRL 4'h4
`define TMO_ADDR_IRQ 4'h8
`define TMO_ADDR_STATUS 4'hc
`define TMO_ADDR_MASK 4'h0

// Interrupt control register bit positions.
`define TMO_BIT_FLAG 2
`define TMO_BIT_ENABLE 5

// Configuration register bit positions.
`define TMO_BIT_SRC 5
`define TMO_BIT_EDGE 4
`define TMO_BIT_PSA 3

// Status and mask bit positions.
`define TMO_ST_OVF 0
`define TMO_ST_EDGE 1
`define TMO_ST_WIDTH 2

// Reset values.
`define TMO_CTRL_RST 8'hff
`define TMO_IRQ_RST 8'h00

// Counter limits.
`define TMO_COUNT_MAX 8'hff
`define TMO_COUNT_MIN 8'h00

// Instruction cycle is four phases of the core oscillator; ref_clk is one phase.
`define TMO_PHASES 2'h3
`define TMO_WRITE_HOLD 2'h2

`endif

/* File: rtl/tmoirq_phase.v */
// Phase generator: turns ref_clk into the four instruction phases and strobes.
// Assumes ref_clk is the core oscillator, one phase per cycle.
`timescale 1ns/100ps
`include "tmoirq_consts.vh"

module tmoirq_phase (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Phase strobes.
  output reg q2_en,
  output reg q4_en
);

  reg [1:0] phase;

  // Phase counter with registered strobes for the second and fourth phase.
  always @(posedge ref_clk) begin
    if (rst) begin
      phase <= 2'h0;
      q2_en <= 1'b0;
      q4_en <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      q2_en <= (phase == 2'h0);
      q4_en <= (phase == 2'h2);
    end
  end

endmodule

/* File: rtl/tmoirq_sync.v */
// Pin synchroniser for the external count input; it outputs a filtered level, and the edges are detected in the top module.
// Assumes the input is asynchronous to ref_clk.
`timescale 1ns/100ps
`include "tmoirq_consts.vh"

module tmoirq_sync (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Raw pin.
  input wire pin_in,
  // Synchronised level.
  output reg level
);

  reg s1;
  reg s2;
  reg s3;

  // Three flops; the level changes only once the last two agree.
  always @(posedge ref_clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule

/* File: rtl/tmoirq_top.v */
// Timer overflow interrupt block: 8-bit timer/counter with overflow flag, enable,
// external count input synchronised on two phases, and a Wishbone register slave.
// Assumes a classic Wishbone master on ref_clk and an asynchronous count pin.
//
// Notes on behaviour
// (R01) Wrap from ff to 00 is overflow.
// (R02) Wrap sets overflow flag, bit two.
// (R03) Enable bit five gates the interrupt.
// (R04) Flag stays set until software clears.
// (R05) Halt stops counting, no overflow.
// (R06) No prescaler: input passes undivided.
// (R07) Input sampled on phases two, four.
// (R08) Source holds each level two phases plus.
// (R09) Timer mode counts each instruction cycle.
// (R10) Counter write blocks two increments.
// (R11) Edge select picks rising or falling.
// (R12) Flag sets even when enable clear.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "tmoirq_consts.vh"

module tmoirq_top (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pins and core status.
  input wire ext_count_input,
  input wire halt,
  // Interrupt outputs.
  output wire overflow_irq,
  output wire irq
);

  reg [7:0] timer_count_register;
  reg [7:0] config_register;
  reg overflow_flag;
  reg overflow_irq_enable;
  reg [`TMO_ST_WIDTH-1:0] status;
  reg [`TMO_ST_WIDTH-1:0] mask;
  reg [1:0] hold_cnt;
  reg sample_q2;
  reg sample_q4;
  reg prev_sample;
  reg [7:0] next_count;
  reg inc;
  reg bump;
  wire q2_en;
  wire q4_en;
  wire pin_level;
  wire prescaler_out;
  wire count_source_select;
  wire source_edge_select;
  wire wb_req;
  wire wr;
  wire wrap;
  wire ext_edge;

  // Decodes a write to one register on the low byte lane.
  function wr_hit;
    input [3:0] adr;
    input [3:0] target;
    input [3:0] sel;
    begin
      wr_hit = (adr == target) && sel[0];
    end
  endfunction

  tmoirq_phase u_phase (
    .ref_clk(ref_clk),
    .rst(rst),
    .q2_en(q2_en),
    .q4_en(q4_en)
  );

  tmoirq_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(ext_count_input),
    .level(pin_level)
  );

  assign count_source_select = config_register[`TMO_BIT_SRC];
  assign source_edge_select = config_register[`TMO_BIT_EDGE];
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = wb_req && wb_we_i;

  // (R06) undivided input path
  // The divider is not modelled, so the pin is the prescaler output as is.
  assign prescaler_out = pin_level;

  // (R07) phase sampling
  // Sampling on Q2 and Q4 is why the source needs two phases per level.
  always @(posedge ref_clk) begin
    if (rst) begin
      sample_q2 <= 1'b0;
      sample_q4 <= 1'b0;
      prev_sample <= 1'b0;
    end else begin
      if (q2_en) begin
        sample_q2 <= prescaler_out;
      end
      if (q4_en) begin
        sample_q4 <= sample_q2;
        prev_sample <= sample_q4;
      end
    end
  end

  // (R11) edge select
  // A rising edge counts when the select bit is clear, a falling one when set.
  assign ext_edge = source_edge_select ? (prev_sample && !sample_q4) : (!prev_sample && sample_q4);

  // Increment decision taken once per instruction cycle at Q4.
  always @* begin
    bump = 1'b0;
    inc = 1'b0;
    if (q4_en) begin
      // (R09) one per cycle
      bump = count_source_select ? ext_edge : 1'b1;
    end
    // (R05) halt stops timer
    // (R10) write inhibit
    inc = bump && !halt && (hold_cnt == 2'h0);
  end

  // (R01) wrap detection
  assign wrap = inc && (timer_count_register == `TMO_COUNT_MAX);

  always @* begin
    next_count = timer_count_register;
    if (inc) begin
      next_count = timer_count_register + 8'h01;
    end
  end

  // Counter and write-inhibit window; a software write outranks an increment.
  always @(posedge ref_clk) begin
    if (rst) begin
      timer_count_register <= `TMO_COUNT_MIN;
      hold_cnt <= 2'h0;
    end else if (wr && wr_hit(wb_adr_i, `TMO_ADDR_COUNT, wb_sel_i)) begin
      timer_count_register <= wb_dat_i[7:0];
      // (R10) block two increments
      hold_cnt <= `TMO_WRITE_HOLD;
    end else begin
      timer_count_register <= next_count;
      if (q4_en && hold_cnt != 2'h0) begin
        hold_cnt <= hold_cnt - 2'h1;
      end
    end
  end

  // Configuration register: source, edge and prescaler assignment bits.
  always @(posedge ref_clk) begin
    if (rst) begin
      config_register <= `TMO_CTRL_RST;
    end else if (wr && wr_hit(wb_adr_i, `TMO_ADDR_CTRL, wb_sel_i)) begin
      config_register <= wb_dat_i[7:0];
    end
  end

  // Interrupt control: flag is set by hardware, cleared only by software.
  // A wrap in the same cycle as a clearing write wins, so no event is lost.
  always @(posedge ref_clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (wr && wr_hit(wb_adr_i, `TMO_ADDR_IRQ, wb_sel_i)) begin
        overflow_irq_enable <= wb_dat_i[`TMO_BIT_ENABLE];
        // (R04) software clear
        overflow_flag <= wb_dat_i[`TMO_BIT_FLAG];
      end
      // (R02) (R12) set regardless of enable
      if (wrap) begin
        overflow_flag <= 1'b1;
      end
    end
  end

  // (R03) enable gating
  assign overflow_irq = overflow_flag && overflow_irq_enable;

  // Sticky status: overflow and external edge events, write one to clear.
  always @(posedge ref_clk) begin
    if (rst) begin
      status <= {`TMO_ST_WIDTH{1'b0}};
      mask <= {`TMO_ST_WIDTH{1'b0}};
    end else begin
      if (wr && wb_adr_i == `TMO_ADDR_STATUS && wb_sel_i[0]) begin
        status <= status & ~wb_dat_i[`TMO_ST_WIDTH-1:0];
      end
      if (wr && wb_adr_i == `TMO_ADDR_STATUS && wb_sel_i[1]) begin
        mask <= wb_dat_i[`TMO_ST_WIDTH+7:8];
      end
      if (wrap) begin
        status[`TMO_ST_OVF] <= 1'b1;
      end
      if (q4_en && ext_edge) begin
        status[`TMO_ST_EDGE] <= 1'b1;
      end
    end
  end

  assign irq = |(status & mask);

  // Wishbone answer: ack one cycle after the request, read data registered with it.
  // Unmapped offsets ack with zero data so a stray access never hangs the bus.
  always @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `TMO_ADDR_COUNT: begin
            wb_dat_o <= {24'h000000, timer_count_register};
          end
          `TMO_ADDR_CTRL: begin
            wb_dat_o <= {24'h000000, config_register};
          end
          `TMO_ADDR_IRQ: begin
            wb_dat_o <= {24'h000000, 2'h0, overflow_irq_enable, 2'h0, overflow_flag, 2'h0};
          end
          `TMO_ADDR_STATUS: begin
            wb_dat_o <= {22'h000000, mask, 6'h00, status};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

/* File: tb/tmoirq_src_model.sv */
// Far-side count source: drives the count pin with whole pulses.
// Assumes calls from the bench just after a rising clock edge.
`timescale 1ns/100ps
module tmoirq_src_model (
  // Clock.
  input wire ref_clk,
  // Count pin.
  output logic pin
);
  initial pin = 1'b0;
  // level hold time
  // Each level stands h clocks; h of 8 or more keeps it above two phases plus the pin delay.
  task pulses(input int n, input int h);
    repeat (n) begin
      pin <= 1'b1;
      repeat (h) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (h) @(posedge ref_clk);
    end
  endtask
endmodule

/* File: tb/tmoirq_chk_monitor.sv */
// Checker for the timer overflow block, bound to its top module.
// Assumes a single clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module tmoirq_chk (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Bus and pins.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire halt,
  // Interrupts.
  input wire overflow_irq,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A taken request, read or write.
  wire req = wb_cyc_i && wb_stb_i;
  ack_next_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  cnt_width_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 4'h0) |-> wb_dat_o[31:8] == 24'h0)
    else $error("count wider than a byte");
  flag_hold_a: assert property ($fell(overflow_irq) |-> $past(req && wb_we_i))
    else $error("overflow interrupt dropped without write");
  status_hold_a: assert property ($fell(irq) |-> $past(req && wb_we_i))
    else $error("interrupt dropped without write");
  halt_quiet_a: assert property ($rose(overflow_irq) && $past(halt) && $past(halt, 2) |-> $past(req))
    else $error("overflow while halted");
endmodule
bind tmoirq_top tmoirq_chk tmoirq_chk_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .halt(halt), .overflow_irq(overflow_irq), .irq(irq));

/* File: tb/tb_top.sv */
// Bench for the timer overflow block: bus tasks, integer model, verdict.
// Assumes the checker binds itself and the source model drives the pin.
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, halt = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, q;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, overflow_irq, irq, pin;
  int failures = 0, checks = 0, ticks = 0, seed = 32'h8dd5, s, n, cnt;
  // Clock at 200 MHz.
  always #2.5 ref_clk = ~ref_clk;
  tmoirq_top tmoirq_top_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_input(pin), .halt(halt),
    .overflow_irq(overflow_irq), .irq(irq));
  tmoirq_src_model tmoirq_src_model_i (.ref_clk(ref_clk), .pin(pin));
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk_dat(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: data %h not %h", $time, got, exp);
    end
  endtask
  task chk_irq(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: level %b not %b", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] sl);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sl;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    chk_irq(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [3:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask
  // Cuts a hang short well past the expected run length.
  always @(posedge ref_clk) begin
    ticks++;
    if (ticks == 5000) begin
      failures++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(4'h4);
    chk_dat(q, 32'hff);
    rd(4'hc);
    chk_dat(q, 32'h0);
    rd(4'h6);
    chk_dat(q, 32'h0);
    // Falling edges from the pin always wrap the count here.
    s = 248 + ($random(seed) & 7);
    n = 9 + ($random(seed) & 3);
    wb(1'b1, 4'h0, s, 4'h1);
    repeat (10) @(posedge ref_clk);
    tmoirq_src_model_i.pulses(n, 8);
    repeat (10) @(posedge ref_clk);
    rd(4'h0);
    chk_dat(q, (s + n) & 255);
    rd(4'hc);
    chk_dat(q, 32'h3);
    chk_irq(overflow_irq, 1'b0);
    // Rising edges, slow source; the flag must survive.
    wb(1'b1, 4'h4, 32'he8, 4'h1);
    s = $random(seed) & 127;
    n = 1 + ($random(seed) & 7);
    wb(1'b1, 4'h0, s, 4'h1);
    repeat (10) @(posedge ref_clk);
    tmoirq_src_model_i.pulses(n, 16);
    repeat (10) @(posedge ref_clk);
    rd(4'h0);
    chk_dat(q, s + n);
    rd(4'h8);
    chk_dat(q & 32'h24, 32'h4);
    // Enable, mask, sticky clear, flag clear.
    wb(1'b1, 4'h8, 32'h24, 4'h1);
    chk_irq(overflow_irq, 1'b1);
    wb(1'b1, 4'hc, 32'h100, 4'h2);
    chk_irq(irq, 1'b1);
    wb(1'b1, 4'hc, 32'h0, 4'h2);
    chk_irq(irq, 1'b0);
    wb(1'b1, 4'hc, 32'h301, 4'h3);
    rd(4'hc);
    chk_dat(q, 32'h302);
    wb(1'b1, 4'hc, 32'h2, 4'h1);
    chk_irq(irq, 1'b0);
    wb(1'b1, 4'h8, 32'h20, 4'h1);
    chk_irq(overflow_irq, 1'b0);
    // Timer mode: write hold-off, then one step per four clocks.
    wb(1'b1, 4'h4, 32'hd8, 4'h1);
    s = $random(seed) & 127;
    wb(1'b1, 4'h0, s, 4'h1);
    rd(4'h0);
    chk_dat(q, s);
    repeat (20) @(posedge ref_clk);
    rd(4'h0);
    cnt = q;
    repeat (61) @(posedge ref_clk);
    rd(4'h0);
    chk_dat(q, (cnt + 16) & 255);
    // Halt freezes the count next to the wrap.
    halt <= 1'b1;
    @(posedge ref_clk);
    wb(1'b1, 4'h0, 32'hfe, 4'h1);
    repeat (200) @(posedge ref_clk);
    rd(4'h0);
    chk_dat(q, 32'hfe);
    rd(4'hc);
    chk_dat(q, 32'h300);
    wb(1'b1, 4'h8, 32'h24, 4'h1);
    halt <= 1'b0;
    print_verdict;
  end
endmodule
